//--- pkg/dcl_pkg.sv
// Shared types and constants for the data cache line state controller.
package dcl_pkg;

  // ---------------------------------------------------------------------------
  // Cache geometry
  // ---------------------------------------------------------------------------
  localparam int WAYS          = 4;
  localparam int LW_PER_LINE   = 4;
  localparam int LINE_OFS_BITS = 4;

  // ---------------------------------------------------------------------------
  // Line states, core operations, memory operations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {LS_INVALID, LS_VALID, LS_DIRTY} dcl_line_st_t;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, LINE_INVALIDATE_OP, LINE_FLUSH_OP} dcl_op_t;
  typedef enum logic [1:0] {MEM_NONE, MEM_FILL, MEM_WRITEBACK, MEM_WRITE_THRU} dcl_mem_op_t;

  // ---------------------------------------------------------------------------
  // Snoop control codes and page cache mode
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SNOOP_LEAVE_DIRTY = 2'h1;
  localparam logic [1:0] SNOOP_INVALIDATE  = 2'h2;
  localparam logic       PCM_WRITE_THROUGH = 1'h1;

  // ---------------------------------------------------------------------------
  // Register map and bus encodings
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  REG_STATUS_OFS   = 8'h04;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
  localparam int          CTRL_SNOOP_EN    = 0;
  localparam int          STAT_BUSY        = 0;
  localparam int          STAT_WAY_LSB     = 4;
  localparam int          STAT_INHIBIT     = 8;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;
  localparam logic [7:0]  LFSR_SEED        = 8'hA5;

endpackage

//--- rtl/dcl_victim_sel.sv
// Replacement way selector: first invalid way, else pseudo-random way.
`timescale 1ns/10ps
`default_nettype none
module dcl_victim_sel
  import dcl_pkg::*;
#(
  parameter int NWAYS = WAYS
) (
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // Per-way occupancy of the looked-up set
  input  wire logic [NWAYS-1:0]         way_invalid,
  // Chosen way
  output logic      [$clog2(NWAYS)-1:0] victim_way
);

  logic [7:0] lfsr_q;

  // Free-running LFSR; it steps every cycle so the choice depends on timing too.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  always_comb begin
    victim_way = lfsr_q[$clog2(NWAYS)-1:0];
    for (int w = NWAYS - 1; w >= 0; w--) begin
      if (way_invalid[w]) begin
        victim_way = w[$clog2(NWAYS)-1:0];
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/dcl_ctrl.sv
// Data cache line state controller with AHB-Lite control and status registers.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dcl_ctrl
  import dcl_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int SETS   = 64
) (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite register slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [31:0]            hrdata,
  // Core request side
  input  wire logic                   core_req,
  input  wire logic [1:0]             core_op,
  input  wire logic [ADDR_W-1:0]      core_addr,
  input  wire logic [LW_PER_LINE-1:0] core_lw_mask,
  input  wire logic                   page_cache_mode,
  output logic                        core_ready,
  output logic                        core_done,
  output logic                        core_hit,
  output logic      [1:0]             core_way,
  // Memory side
  output logic                        mem_req,
  output logic      [1:0]             mem_op,
  output logic      [$clog2(SETS)-1:0] mem_set,
  output logic      [ADDR_W-LINE_OFS_BITS-$clog2(SETS)-1:0] mem_tag,
  output logic      [1:0]             mem_way,
  output logic                        victim_buffer,
  input  wire logic                   mem_ack,
  // Alternate master snoop side
  input  wire logic                   snoop_valid,
  input  wire logic                   snoop_we,
  input  wire logic [ADDR_W-1:0]      snoop_addr,
  input  wire logic [1:0]             snoop_control_code,
  input  wire logic                   snoop_line_size,
  input  wire logic [LW_PER_LINE-1:0] snoop_lw_mask,
  output logic                        memory_inhibit_out,
  output logic                        snoop_supply,
  output logic                        snoop_sink
);

  localparam int SET_BITS = $clog2(SETS);
  localparam int TAG_W    = ADDR_W - LINE_OFS_BITS - SET_BITS;

  typedef enum logic [2:0] {ST_IDLE, ST_BUFFER, ST_FILL, ST_WRITEBACK, ST_WRITE_THRU, ST_PUSH} dcl_fsm_t;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  dcl_line_st_t st_q [SETS][WAYS];
  logic [LW_PER_LINE-1:0] dty_q [SETS][WAYS];
  logic [TAG_W-1:0]       tag_q [SETS][WAYS];
  dcl_fsm_t state_q, state_d;
  logic [SET_BITS-1:0] c_set, s_set, req_set_q, lw_set;
  logic [TAG_W-1:0]    c_tag, s_tag, req_tag_q, vtag_q;
  logic [WAYS-1:0]     c_hit, c_inv, s_hit;
  logic [1:0]          c_way, s_way, v_way, tgt_way, req_way_q, lw_way;
  logic c_hit_any, s_hit_any, v_dirty, take, s_act, ld_req, done_d, hit_d;
  logic lw_en, tag_en, sw_en, inh_d, sup_d, snk_d, buffered_q, req_hit_q, req_wr_q;
  dcl_line_st_t c_st, s_st, lw_st, sw_st;
  logic [LW_PER_LINE-1:0] lw_dty, sw_dty, req_mask_q;
  dcl_op_t c_op;
  logic [31:0] ctrl_q;
  logic [7:0]  bus_addr_q;
  logic        bus_wr_q, bus_ap;

  function automatic logic [1:0] way_of(input logic [WAYS-1:0] v);
    way_of = 2'h0;
    for (int i = 0; i < WAYS; i++) begin
      if (v[i]) begin
        way_of = i[1:0];
      end
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Tag lookup for the core and the snoop port
  // ---------------------------------------------------------------------------
  assign c_set = core_addr[LINE_OFS_BITS +: SET_BITS];
  assign c_tag = core_addr[ADDR_W-1 -: TAG_W];
  assign s_set = snoop_addr[LINE_OFS_BITS +: SET_BITS];
  assign s_tag = snoop_addr[ADDR_W-1 -: TAG_W];
  assign c_op  = dcl_op_t'(core_op);

  for (genvar w = 0; w < WAYS; w++) begin : g_way
    assign c_inv[w] = (st_q[c_set][w] == LS_INVALID);
    assign c_hit[w] = !c_inv[w] && (tag_q[c_set][w] == c_tag);
    assign s_hit[w] = (st_q[s_set][w] != LS_INVALID) && (tag_q[s_set][w] == s_tag);
  end

  assign c_hit_any = |c_hit;
  assign s_hit_any = |s_hit;
  assign c_way     = way_of(c_hit);
  assign s_way     = way_of(s_hit);
  assign c_st      = st_q[c_set][c_way];
  assign s_st      = st_q[s_set][s_way];
  assign v_dirty   = (st_q[c_set][v_way] == LS_DIRTY);
  assign tgt_way   = c_hit_any ? c_way : v_way;

  dcl_victim_sel #(.NWAYS(WAYS)) u_victim (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .way_invalid(c_inv),
    .victim_way (v_way)
  );

  // Snoops win the cycle; the core waits rather than racing a snoop on the same set.
  assign s_act      = snoop_valid && ctrl_q[CTRL_SNOOP_EN];
  assign core_ready = (state_q == ST_IDLE) && !s_act;
  assign take       = core_req && core_ready;
  assign mem_req    = (state_q == ST_FILL) || (state_q == ST_WRITEBACK) ||
                      (state_q == ST_WRITE_THRU) || (state_q == ST_PUSH);

  // ---------------------------------------------------------------------------
  // Core sequencer, next state and line updates
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ld_req  = 1'b0;
    done_d  = 1'b0;
    hit_d   = 1'b0;
    lw_en   = 1'b0;
    tag_en  = 1'b0;
    lw_set  = req_set_q;
    lw_way  = req_way_q;
    lw_st   = LS_INVALID;
    lw_dty  = '0;
    unique case (state_q)
      ST_IDLE: if (take) begin
        ld_req = 1'b1;
        lw_set = c_set;
        lw_way = c_way;
        unique case (c_op)
          OP_READ: if (c_hit_any) begin
            done_d = 1'b1;
            hit_d  = 1'b1;
          end else begin
            state_d = v_dirty ? ST_BUFFER : ST_FILL;
          end
          OP_WRITE: if (page_cache_mode == PCM_WRITE_THROUGH) begin
            state_d = ST_WRITE_THRU;
          end else if (c_hit_any) begin
            done_d = 1'b1;
            hit_d  = 1'b1;
            lw_en  = 1'b1;
            lw_st  = LS_DIRTY;
            lw_dty = dty_q[c_set][c_way] | core_lw_mask;
          end else begin
            state_d = v_dirty ? ST_BUFFER : ST_FILL;
          end
          LINE_INVALIDATE_OP: begin
            done_d = 1'b1;
            hit_d  = c_hit_any;
            lw_en  = c_hit_any;
          end
          LINE_FLUSH_OP: if (c_hit_any && c_st == LS_DIRTY) begin
            state_d = ST_PUSH;
          end else begin
            done_d = 1'b1;
            hit_d  = c_hit_any;
            lw_en  = c_hit_any;
          end
        endcase
      end
      ST_BUFFER: state_d = ST_FILL;
      ST_FILL: if (mem_ack) begin
        done_d  = 1'b1;
        lw_en   = 1'b1;
        tag_en  = 1'b1;
        lw_st   = req_wr_q ? LS_DIRTY : LS_VALID;
        lw_dty  = req_wr_q ? req_mask_q : '0;
        state_d = buffered_q ? ST_WRITEBACK : ST_IDLE;
      end
      ST_WRITEBACK: if (mem_ack) begin
        state_d = ST_IDLE;
      end
      ST_WRITE_THRU: if (mem_ack) begin
        done_d  = 1'b1;
        hit_d   = req_hit_q;
        state_d = ST_IDLE;
      end
      ST_PUSH: if (mem_ack) begin
        done_d  = 1'b1;
        hit_d   = 1'b1;
        lw_en   = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state, captured request and registered handshake outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q       <= ST_IDLE;
      req_set_q     <= '0;
      req_tag_q     <= '0;
      vtag_q        <= '0;
      req_way_q     <= 2'h0;
      req_mask_q    <= '0;
      req_wr_q      <= 1'b0;
      req_hit_q     <= 1'b0;
      buffered_q    <= 1'b0;
      core_done     <= 1'b0;
      core_hit      <= 1'b0;
      core_way      <= 2'h0;
      mem_op        <= MEM_NONE;
      mem_set       <= '0;
      mem_tag       <= '0;
      mem_way       <= 2'h0;
      victim_buffer <= 1'b0;
    end else begin
      state_q       <= state_d;
      core_done     <= done_d;
      core_hit      <= hit_d;
      victim_buffer <= (state_d == ST_BUFFER);
      if (ld_req) begin
        req_set_q  <= c_set;
        req_tag_q  <= c_tag;
        vtag_q     <= tag_q[c_set][v_way];
        req_way_q  <= tgt_way;
        req_mask_q <= core_lw_mask;
        req_wr_q   <= (c_op == OP_WRITE);
        req_hit_q  <= c_hit_any;
        buffered_q <= (state_d == ST_BUFFER);
        core_way   <= tgt_way;
        mem_set    <= c_set;
        mem_way    <= tgt_way;
      end
      mem_tag <= (state_d == ST_WRITEBACK) ? vtag_q : (ld_req ? c_tag : req_tag_q);
      unique case (state_d)
        ST_FILL:       mem_op <= MEM_FILL;
        ST_WRITEBACK:  mem_op <= MEM_WRITEBACK;
        ST_PUSH:       mem_op <= MEM_WRITEBACK;
        ST_WRITE_THRU: mem_op <= MEM_WRITE_THRU;
        default:       mem_op <= MEM_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Snoop decode
  // ---------------------------------------------------------------------------
  always_comb begin
    sw_en  = 1'b0;
    sw_st  = LS_INVALID;
    sw_dty = '0;
    inh_d  = 1'b0;
    sup_d  = 1'b0;
    snk_d  = 1'b0;
    if (s_act && s_hit_any &&
        (snoop_control_code == SNOOP_LEAVE_DIRTY || snoop_control_code == SNOOP_INVALIDATE)) begin
      if (!snoop_we) begin
        inh_d = (s_st == LS_DIRTY);
        sup_d = (s_st == LS_DIRTY);
        sw_en = (snoop_control_code == SNOOP_INVALIDATE);
      end else if (s_st == LS_DIRTY && snoop_control_code == SNOOP_LEAVE_DIRTY && !snoop_line_size) begin
        inh_d  = 1'b1;
        snk_d  = 1'b1;
        sw_en  = 1'b1;
        sw_st  = LS_DIRTY;
        sw_dty = dty_q[s_set][s_way] | snoop_lw_mask;
      end else begin
        sw_en = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      memory_inhibit_out <= 1'b0;
      snoop_supply       <= 1'b0;
      snoop_sink         <= 1'b0;
    end else begin
      memory_inhibit_out <= inh_d;
      snoop_supply       <= sup_d;
      snoop_sink         <= snk_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Line state store
  // ---------------------------------------------------------------------------
  // Snoop update is applied last so it wins over a core update to the same line.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int s = 0; s < SETS; s++) begin
        for (int w = 0; w < WAYS; w++) begin
          st_q[s][w]  <= LS_INVALID;
          dty_q[s][w] <= '0;
        end
      end
    end else begin
      if (lw_en) begin
        st_q[lw_set][lw_way]  <= lw_st;
        dty_q[lw_set][lw_way] <= lw_dty;
      end
      if (sw_en) begin
        st_q[s_set][s_way]  <= sw_st;
        dty_q[s_set][s_way] <= sw_dty;
      end
    end
  end

  // Tags are only meaningful under a non-invalid state, so they need no reset.
  always_ff @(posedge hclk) begin
    if (tag_en) begin
      tag_q[req_set_q][req_way_q] <= req_tag_q;
    end
  end

  // ---------------------------------------------------------------------------
  // AHB-Lite register slave
  // ---------------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign bus_ap    = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

  // Address phase capture; read data is registered for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_q   <= 1'b0;
      bus_addr_q <= 8'h00;
      hrdata     <= 32'h0000_0000;
    end else begin
      bus_wr_q   <= bus_ap && hwrite && haddr[31:8] == 24'h000000;
      bus_addr_q <= haddr[7:0];
      hrdata     <= 32'h0000_0000;
      if (bus_ap && !hwrite && haddr[31:8] == 24'h000000) begin
        if (haddr[7:0] == REG_CTRL_OFS) begin
          hrdata <= ctrl_q;
        end else if (haddr[7:0] == REG_STATUS_OFS) begin
          hrdata[STAT_BUSY]                   <= (state_q != ST_IDLE);
          hrdata[STAT_WAY_LSB +: 2]           <= req_way_q;
          hrdata[STAT_INHIBIT]                <= memory_inhibit_out;
        end
      end
    end
  end

  // Control register write in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (bus_wr_q && bus_addr_q == REG_CTRL_OFS) begin
      ctrl_q <= {31'h0000_0000, hwdata[CTRL_SNOOP_EN]};
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_dirty_miss;
    take && !c_hit_any && v_dirty &&
    (c_op == OP_READ || (c_op == OP_WRITE && page_cache_mode != PCM_WRITE_THROUGH));
  endsequence
  sequence s_buffer_fill;
    state_q == ST_BUFFER && victim_buffer ##1 state_q == ST_FILL;
  endsequence

  property p_dirty_order;
    @(posedge hclk) disable iff (!hresetn) s_dirty_miss |=> s_buffer_fill;
  endproperty
  a_dirty_order: assert property (p_dirty_order) else $error("dirty victim not buffered before fill");

  property p_fill_then_wb;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == ST_FILL && mem_ack && buffered_q) |=> (core_done && state_q == ST_WRITEBACK && mem_op == MEM_WRITEBACK);
  endproperty
  a_fill_then_wb: assert property (p_fill_then_wb) else $error("buffered victim not written after fill");

  property p_read_hit;
    @(posedge hclk) disable iff (!hresetn)
      (take && c_op == OP_READ && c_hit_any) |=> (core_done && core_hit && !mem_req);
  endproperty
  a_read_hit: assert property (p_read_hit) else $error("read hit did not complete from cache");

  property p_wt_no_alloc;
    @(posedge hclk) disable iff (!hresetn)
      (take && c_op == OP_WRITE && page_cache_mode == PCM_WRITE_THROUGH) |=>
      (mem_op == MEM_WRITE_THRU && !victim_buffer);
  endproperty
  a_wt_no_alloc: assert property (p_wt_no_alloc) else $error("write-through write not sent to memory");

  property p_snoop_rd_dirty;
    @(posedge hclk) disable iff (!hresetn)
      (s_act && !snoop_we && s_hit_any && s_st == LS_DIRTY && snoop_control_code == SNOOP_LEAVE_DIRTY) |=>
      (memory_inhibit_out && snoop_supply && !snoop_sink);
  endproperty
  a_snoop_rd_dirty: assert property (p_snoop_rd_dirty) else $error("dirty snoop read not sourced");

  property p_snoop_miss;
    @(posedge hclk) disable iff (!hresetn) (snoop_valid && !s_hit_any) |=> !memory_inhibit_out;
  endproperty
  a_snoop_miss: assert property (p_snoop_miss) else $error("inhibit raised on snoop miss");

  property p_full_write_no_inhibit;
    @(posedge hclk) disable iff (!hresetn) (s_act && snoop_we && snoop_line_size) |=> !memory_inhibit_out;
  endproperty
  a_full_write_no_inhibit: assert property (p_full_write_no_inhibit) else $error("full line snoop write inhibited");

  property p_flush_dirty;
    @(posedge hclk) disable iff (!hresetn)
      (take && c_op == LINE_FLUSH_OP && c_hit_any && c_st == LS_DIRTY) |=> (mem_req && mem_op == MEM_WRITEBACK && !core_done);
  endproperty
  a_flush_dirty: assert property (p_flush_dirty) else $error("dirty flush did not write back");

  property p_invalidate;
    @(posedge hclk) disable iff (!hresetn) (take && c_op == LINE_INVALIDATE_OP) |=> (core_done && !mem_req);
  endproperty
  a_invalidate: assert property (p_invalidate) else $error("invalidate touched memory");

  property p_victim_invalid;
    @(posedge hclk) disable iff (!hresetn) (take && !c_hit_any && |c_inv) |-> c_inv[v_way];
  endproperty
  a_victim_invalid: assert property (p_victim_invalid) else $error("valid victim chosen over invalid way");

  property p_mem_hold;
    @(posedge hclk) disable iff (!hresetn) (mem_req && !mem_ack) |=> (mem_req && $stable(mem_op) && $stable(mem_tag));
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped before acknowledge");

endmodule
`default_nettype wire

//--- verif/dcl_mem_model.sv
// Memory responder answering the cache's line requests.
`timescale 1ns/10ps
`default_nettype none
module dcl_mem_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Request, answer delay and answer
  input  wire logic       mem_req,
  input  wire logic [3:0] dly,
  output logic            mem_ack
);
  logic [3:0] wait_q;

  // answer requests
  // Acks only a live request, after dly waiting cycles, so slow memory is exercised too.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q  <= 4'h0;
      mem_ack <= 1'b0;
    end else if (mem_req && !mem_ack && wait_q == dly) begin
      wait_q  <= 4'h0;
      mem_ack <= 1'b1;
    end else begin
      mem_ack <= 1'b0;
      wait_q  <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- verif/dcl_ctrl_test.sv
// Self-checking bench for the cache line state controller.
`timescale 1ns/10ps
`default_nettype none
module dcl_ctrl_test import dcl_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, core_req, page_cache_mode, snoop_valid, snoop_we;
  logic snoop_line_size, hreadyout, core_ready, core_done, core_hit, mem_req, mem_ack;
  logic victim_buffer, memory_inhibit_out, snoop_supply, snoop_sink, vb_seen;
  logic [31:0] haddr, hwdata, core_addr, snoop_addr, hrdata, rd;
  logic [1:0]  htrans, core_op, snoop_control_code, mem_op;
  logic [3:0]  dly;
  logic [5:0]  seq;
  logic [25:0] mtag, tag_seen;
  int          fail_count, n_compared, cyc;

  dcl_ctrl #(.ADDR_W(32), .SETS(4)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .core_req,
    .core_op, .core_addr, .core_lw_mask(4'h1), .page_cache_mode, .core_ready, .core_done,
    .core_hit, .core_way(), .mem_req, .mem_op, .mem_set(), .mem_tag(mtag), .mem_way(), .victim_buffer,
    .mem_ack, .snoop_valid, .snoop_we, .snoop_addr, .snoop_control_code, .snoop_line_size,
    .snoop_lw_mask(4'h3), .memory_inhibit_out, .snoop_supply, .snoop_sink);
  dcl_mem_model mem_u (.hclk, .hresetn, .mem_req, .dly, .mem_ack);

  // Clock, memory-op log and hang limit.
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (mem_req && mem_ack) seq <= {seq[3:0], mem_op};
    if (mem_req && mem_ack) tag_seen <= mtag;
    if (victim_buffer) vb_seen <= 1'b1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // AHB-Lite single word transfer; read data lands in rd.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  endtask
  // Core request; checks hit flag and the memory ops issued (oldest in the upper bits).
  task automatic cop(input logic [1:0] op, input logic [31:0] a, input logic wt,
                     input logic hit, input logic [5:0] ops);
    @(posedge hclk);
    core_req <= 1'b1;
    core_op <= op;
    core_addr <= a;
    page_cache_mode <= wt;
    seq <= 6'h00;
    vb_seen <= 1'b0;
    do @(negedge hclk); while (!core_ready);
    @(posedge hclk);
    core_req <= 1'b0;
    do @(negedge hclk); while (!core_done);
    chk(32'(core_hit), 32'(hit));
    do @(negedge hclk); while (!core_ready || mem_req);
    chk(32'(seq), 32'(ops));
  endtask
  // Alternate master access; checks {inhibit, supply, sink} one cycle later.
  task automatic snp(input logic we, input logic [1:0] sc, input logic [31:0] a,
                     input logic ln, input logic [2:0] exp);
    @(posedge hclk);
    snoop_valid <= 1'b1;
    snoop_we <= we;
    snoop_control_code <= sc;
    snoop_addr <= a;
    snoop_line_size <= ln;
    @(posedge hclk);
    snoop_valid <= 1'b0;
    @(negedge hclk);
    chk(32'({memory_inhibit_out, snoop_supply, snoop_sink}), 32'(exp));
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, core_req, page_cache_mode, snoop_valid, snoop_we} = '0;
    {snoop_line_size, haddr, hwdata, core_addr, snoop_addr, htrans, core_op} = '0;
    {snoop_control_code, seq, vb_seen, fail_count, n_compared, cyc, dly, tag_seen} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, CTRL_RESET);
    cop(OP_READ, 32'h1000, 1'b0, 1'b0, 6'h01);
    cop(OP_READ, 32'h1000, 1'b0, 1'b1, 6'h00);
    dly <= 4'h3;
    cop(OP_WRITE, 32'h1000, 1'b1, 1'b1, 6'h03);
    cop(OP_WRITE, 32'h1000, 1'b0, 1'b1, 6'h00);
    cop(OP_WRITE, 32'h1000, 1'b1, 1'b1, 6'h03);
    cop(OP_WRITE, 32'h1000, 1'b0, 1'b1, 6'h00);
    snp(1'b0, 2'h1, 32'h1000, 1'b0, 3'h6);
    snp(1'b1, 2'h1, 32'h1000, 1'b0, 3'h5);
    snp(1'b0, 2'h2, 32'h1000, 1'b0, 3'h6);
    snp(1'b0, 2'h1, 32'h1000, 1'b0, 3'h0);
    cop(OP_READ, 32'h1000, 1'b0, 1'b0, 6'h01);
    snp(1'b0, 2'h1, 32'h1000, 1'b0, 3'h0);
    snp(1'b0, 2'h2, 32'h1000, 1'b0, 3'h0);
    cop(OP_WRITE, 32'h1000, 1'b0, 1'b0, 6'h01);
    snp(1'b1, 2'h1, 32'h1000, 1'b1, 3'h0);
    cop(OP_WRITE, 32'h1000, 1'b0, 1'b0, 6'h01);
    snp(1'b1, 2'h2, 32'h1000, 1'b0, 3'h0);
    cop(LINE_FLUSH_OP, 32'h1000, 1'b0, 1'b0, 6'h00);
    cop(OP_WRITE, 32'h1000, 1'b0, 1'b0, 6'h01);
    cop(LINE_FLUSH_OP, 32'h1000, 1'b0, 1'b1, 6'h02);
    chk(32'(tag_seen), 32'h40);
    cop(OP_READ, 32'h1000, 1'b0, 1'b0, 6'h01);
    cop(LINE_FLUSH_OP, 32'h1000, 1'b0, 1'b1, 6'h00);
    cop(OP_WRITE, 32'h1000, 1'b0, 1'b0, 6'h01);
    cop(LINE_INVALIDATE_OP, 32'h1000, 1'b0, 1'b1, 6'h00);
    snp(1'b0, 2'h1, 32'h1000, 1'b0, 3'h0);
    cop(LINE_INVALIDATE_OP, 32'h1000, 1'b0, 1'b0, 6'h00);
    cop(OP_WRITE, 32'h2000, 1'b1, 1'b0, 6'h03);
    chk(32'(tag_seen), 32'h80);
    cop(OP_READ, 32'h2000, 1'b0, 1'b0, 6'h01);
    dly <= 4'h0;
    // Fill one set with dirty lines, then force dirty evictions.
    for (int k = 0; k < 4; k++) begin
      cop(OP_WRITE, 32'h10 + 32'(k) * 32'h40, 1'b0, 1'b0, 6'h01);
    end
    // The last fill took the last free way, so status shows way 3.
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h3 << STAT_WAY_LSB);
    cop(OP_WRITE, 32'h110, 1'b0, 1'b0, 6'h06);
    chk(32'(vb_seen), 32'h1);
    cop(OP_READ, 32'h150, 1'b0, 1'b0, 6'h06);
    snp(1'b0, 2'h1, 32'h150, 1'b0, 3'h0);
    // The victim is random, so only the line just filled is known to be present.
    cop(OP_WRITE, 32'h150, 1'b0, 1'b1, 6'h00);
    ahb(1'b1, 32'h0, 32'h0);
    snp(1'b0, 2'h1, 32'h150, 1'b0, 3'h0);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h0, 32'h1);
    snp(1'b0, 2'h1, 32'h150, 1'b0, 3'h6);
    complete_run();
  end
endmodule
`default_nettype wire
